/* rtl/wdc_top.v */
// Purpose: control flags, interval select, timed-access lock and
//          delayed reset of the core watchdog timer
// Assumes: reset-cause inputs and bus strobes are synchronous
//          one-cycle or level signals in the CORE_CLK domain
// Notes:   timeout counts are parameters so a bench can shorten them
//
// Notes on behaviour
// - power-on sets the power-on flag; only a software write clears it
// - with the watchdog interrupt enabled, a timeout sets the timeout flag
// - with it disabled the timeout flag is set too; only software clears it
// - a watchdog reset sets the reset flag, which survives that reset
// - a power-fail reset clears the watchdog reset flag
// - with reset enable low the watchdog leaves the reset flag alone
// - reset enable arms the watchdog reset; low means no reset at all
// - restart clears the counter and then clears itself
// - a timeout raises the watchdog interrupt request when enabled
// - with reset enabled and no restart, reset follows 512 clocks later
// - reset enable, timeout flag and restart need the aa then 55 unlock
// - a two-bit field in clock control selects the timeout interval
// - the interval field resets to the shortest, two to the seventeenth
// - field values 0..3 give 2^17, 2^20, 2^23 and 2^26 clocks
// - the watchdog reset lasts two machine cycles
// - power-on or power-fail disables; external or watchdog reset zeroes the count; only restart re-enables
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "wdc_defines.vh"

module wdc_top #(
  parameter [31:0] TO_SEL0 = `WDC_TO_SEL0,
  parameter [31:0] TO_SEL1 = `WDC_TO_SEL1,
  parameter [31:0] TO_SEL2 = `WDC_TO_SEL2,
  parameter [31:0] TO_SEL3 = `WDC_TO_SEL3
) (
  input  wire                   CORE_CLK,
  input  wire                   ARST_N,
  input  wire [`WDC_ADDR_W-1:0] ADDR,
  input  wire [7:0]             WDATA,
  input  wire                   WR,
  input  wire                   RD,
  output reg  [7:0]             RDATA,
  input  wire                   PWR_ON_RST,
  input  wire                   PWR_FAIL_RST,
  input  wire                   EXT_RST,
  output reg                    WD_IRQ_REQ,
  output reg                    WD_RST_OUT,
  output reg                    IRQ
);

  // --------------------------------------------------------------
  // states of the timeout sequence
  // --------------------------------------------------------------
  localparam [2:0] ST_COUNT = 3'b001;
  localparam [2:0] ST_DELAY = 3'b010;
  localparam [2:0] ST_RESET = 3'b100;

  // terminal count of the selected interval, minus one
  function [`WDC_CNT_W-1:0] sel_last;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    sel_last = TO_SEL0[`WDC_CNT_W-1:0] - 1'b1;
        2'h1:    sel_last = TO_SEL1[`WDC_CNT_W-1:0] - 1'b1;
        2'h2:    sel_last = TO_SEL2[`WDC_CNT_W-1:0] - 1'b1;
        default: sel_last = TO_SEL3[`WDC_CNT_W-1:0] - 1'b1;
      endcase
    end
  endfunction

  // --------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------
  reg [1:0] rst_sync_reg;
  wire      rst_n = rst_sync_reg[1];

  // release is delayed two edges so all flops leave reset together
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  reg                   por_reg;
  reg                   timeout_flag_reg;
  reg                   wrst_flag_reg;
  reg                   rst_en_reg;
  reg                   run_reg;
  reg [1:0]             sel_reg;
  reg                   irq_en_reg;
  reg [`WDC_NUM_EV-1:0] status_reg;
  reg [`WDC_NUM_EV-1:0] mask_reg;
  reg                   key_half_reg;
  reg [3:0]             ta_win_reg;
  reg [2:0]             state_reg;
  reg [`WDC_CNT_W-1:0]  cnt_reg;
  reg [9:0]             dly_reg;
  reg [3:0]             rlen_reg;

  // --------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------
  wire wr_ctrl   = WR && (ADDR == `WDC_OFF_CONTROL);
  wire wr_key    = WR && (ADDR == `WDC_OFF_TA_KEY);
  wire wr_clk    = WR && (ADDR == `WDC_OFF_CLK_CTRL);
  wire wr_irq_en = WR && (ADDR == `WDC_OFF_IRQ_EN);
  wire wr_mask   = WR && (ADDR == `WDC_OFF_MASK);
  wire rd_status = RD && (ADDR == `WDC_OFF_STATUS);
  wire unlocked  = (ta_win_reg != 4'h0);
  wire wr_prot   = wr_ctrl && unlocked;
  wire restart   = wr_prot && WDATA[`WDC_BIT_RESTART];

  // --------------------------------------------------------------
  // timed-access key
  // --------------------------------------------------------------
  // the window is short on purpose: errant code rarely hits both
  // keys and then the control register inside a few cycles
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      key_half_reg <= 1'b0;
      ta_win_reg   <= 4'h0;
    end else begin
      if (wr_key) begin
        key_half_reg <= (WDATA == `WDC_KEY_FIRST);
      end
      if (wr_key && key_half_reg && (WDATA == `WDC_KEY_SECOND)) begin
        ta_win_reg <= `WDC_TA_WINDOW;
      end else if (wr_ctrl) begin
        ta_win_reg <= 4'h0;                                    // one write per unlock
      end else if (unlocked) begin
        ta_win_reg <= ta_win_reg - 4'h1;
      end
    end
  end

  // --------------------------------------------------------------
  // timeout sequence
  // --------------------------------------------------------------
  wire hard_rst   = PWR_ON_RST || PWR_FAIL_RST;
  wire at_last    = (cnt_reg == sel_last(sel_reg));
  wire timeout_ev = run_reg && at_last && !restart && !hard_rst;
  wire rst_start  = (state_reg == ST_DELAY) && (dly_reg == 10'd1) && !restart;
  wire rst_done   = (state_reg == ST_RESET) && (rlen_reg == 4'h1);

  reg [2:0] state_next;
  // next state of the delayed reset sequence
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_COUNT: begin
        if (timeout_ev && rst_en_reg) begin
          state_next = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (restart || !rst_en_reg) begin
          state_next = ST_COUNT;
        end else if (rst_start) begin
          state_next = ST_RESET;
        end
      end
      ST_RESET: begin
        if (rst_done) begin
          state_next = ST_COUNT;
        end
      end
      default: begin
        state_next = ST_COUNT;
      end
    endcase
    if (hard_rst || EXT_RST) begin
      state_next = ST_COUNT;
    end
  end

  // counter, delay and reset length
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= ST_COUNT;
      cnt_reg    <= {`WDC_CNT_W{1'b0}};
      dly_reg    <= 10'd0;
      rlen_reg   <= 4'h0;
      run_reg    <= 1'b0;
      WD_RST_OUT <= 1'b0;
    end else begin
      state_reg <= state_next;
      // disabled by power loss, set running again only by a software restart
      if (hard_rst) begin
        run_reg <= 1'b0;
      end else if (restart) begin
        run_reg <= 1'b1;
      end
      if (hard_rst || EXT_RST || restart || rst_done || at_last) begin
        cnt_reg <= {`WDC_CNT_W{1'b0}};
      end else if (run_reg) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
      if (state_next == ST_DELAY && state_reg != ST_DELAY) begin
        dly_reg <= `WDC_RST_DELAY;
      end else if (state_reg == ST_DELAY) begin
        dly_reg <= dly_reg - 10'd1;
      end
      if (state_next == ST_RESET && state_reg != ST_RESET) begin
        rlen_reg   <= `WDC_RST_LEN;
        WD_RST_OUT <= 1'b1;
      end else if (state_reg == ST_RESET && state_next == ST_RESET) begin
        rlen_reg <= rlen_reg - 4'h1;
      end else begin
        rlen_reg   <= 4'h0;
        WD_RST_OUT <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // control flags
  // --------------------------------------------------------------
  wire wrst_ev = rst_start && rst_en_reg;

  // hardware set wins over a software clear in the same cycle
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      por_reg          <= 1'b0;
      timeout_flag_reg <= 1'b0;
      wrst_flag_reg    <= 1'b0;
      rst_en_reg       <= 1'b0;
      sel_reg          <= `WDC_SEL_RESET;
      irq_en_reg       <= 1'b0;
    end else begin
      if (PWR_ON_RST) begin
        por_reg <= 1'b1;
      end else if (wr_ctrl) begin
        por_reg <= WDATA[`WDC_BIT_POR];
      end
      if (timeout_ev) begin
        timeout_flag_reg <= 1'b1;
      end else if (wr_prot) begin
        timeout_flag_reg <= WDATA[`WDC_BIT_TIMEOUT];
      end
      if (PWR_FAIL_RST) begin
        wrst_flag_reg <= 1'b0;
      end else if (wrst_ev) begin
        wrst_flag_reg <= 1'b1;
      end else if (wr_ctrl && !WDATA[`WDC_BIT_WRST]) begin
        wrst_flag_reg <= 1'b0;                                 // software clear only
      end
      if (hard_rst) begin
        rst_en_reg <= 1'b0;
      end else if (wr_prot) begin
        rst_en_reg <= WDATA[`WDC_BIT_RST_EN];
      end
      if (hard_rst) begin
        irq_en_reg <= 1'b0;
      end else if (wr_irq_en) begin
        irq_en_reg <= WDATA[`WDC_BIT_WD_IRQ_EN];
      end
      if (wr_clk) begin
        sel_reg <= {WDATA[`WDC_BIT_SEL_HI], WDATA[`WDC_BIT_SEL_LO]};
      end
    end
  end

  // --------------------------------------------------------------
  // interrupt status and mask
  // --------------------------------------------------------------
  wire [`WDC_NUM_EV-1:0] ev_vec;
  wire [`WDC_NUM_EV-1:0] status_next;
  wire [`WDC_NUM_EV-1:0] mask_next;

  assign ev_vec[`WDC_EV_TIMEOUT] = timeout_ev;
  assign ev_vec[`WDC_EV_WRST]    = wrst_ev;
  assign mask_next = wr_mask ? WDATA[`WDC_NUM_EV-1:0] : mask_reg;

  // sticky bits cleared by reading; an event in the read cycle stays
  genvar gi;
  generate
    for (gi = 0; gi < `WDC_NUM_EV; gi = gi + 1) begin : g_stat
      assign status_next[gi] = ev_vec[gi] | (status_reg[gi] & ~rd_status);
    end
  endgenerate

  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= {`WDC_NUM_EV{1'b0}};
      mask_reg   <= `WDC_MASK_RESET;
      IRQ        <= 1'b0;
      WD_IRQ_REQ <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      IRQ        <= |(status_next & mask_next);
      // level request to the interrupt controller
      WD_IRQ_REQ <= irq_en_reg & (timeout_flag_reg | timeout_ev);
    end
  end

  // --------------------------------------------------------------
  // read data
  // --------------------------------------------------------------
  reg [7:0] rd_next;
  // restart reads zero because it clears itself at once
  always @* begin
    rd_next = 8'h00;
    case (ADDR)
      `WDC_OFF_CONTROL: begin
        rd_next[`WDC_BIT_POR]     = por_reg;
        rd_next[`WDC_BIT_TIMEOUT] = timeout_flag_reg;
        rd_next[`WDC_BIT_WRST]    = wrst_flag_reg;
        rd_next[`WDC_BIT_RST_EN]  = rst_en_reg;
      end
      `WDC_OFF_CLK_CTRL: begin
        rd_next[`WDC_BIT_SEL_HI] = sel_reg[1];
        rd_next[`WDC_BIT_SEL_LO] = sel_reg[0];
      end
      `WDC_OFF_IRQ_EN: begin
        rd_next[`WDC_BIT_WD_IRQ_EN] = irq_en_reg;
      end
      `WDC_OFF_STATUS: begin
        rd_next[`WDC_NUM_EV-1:0] = status_reg;
      end
      `WDC_OFF_MASK: begin
        rd_next[`WDC_NUM_EV-1:0] = mask_reg;
      end
      default: begin
        rd_next = 8'h00;
      end
    endcase
  end

  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= rd_next;
    end else begin
      RDATA <= 8'h00;
    end
  end

endmodule

/* common/wdc_defines.vh */
// Purpose: constants of the watchdog control and status block
// Assumes: byte-wide register port, 100 MHz core clock
// Notes:   offsets are byte addresses on the plain register port
`ifndef WDC_DEFINES_VH
`define WDC_DEFINES_VH

// --------------------------------------------------------------
// register offsets
// --------------------------------------------------------------
`define WDC_ADDR_W        4
`define WDC_OFF_CONTROL   4'h0
`define WDC_OFF_TA_KEY    4'h1
`define WDC_OFF_CLK_CTRL  4'h2
`define WDC_OFF_IRQ_EN    4'h3
`define WDC_OFF_STATUS    4'h4
`define WDC_OFF_MASK      4'h5

// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define WDC_BIT_POR       6
`define WDC_BIT_TIMEOUT   3
`define WDC_BIT_WRST      2
`define WDC_BIT_RST_EN    1
`define WDC_BIT_RESTART   0
`define WDC_BIT_SEL_HI    7
`define WDC_BIT_SEL_LO    6
`define WDC_BIT_WD_IRQ_EN 4
`define WDC_EV_TIMEOUT    0
`define WDC_EV_WRST       1
`define WDC_NUM_EV        2

// --------------------------------------------------------------
// reset values and keys
// --------------------------------------------------------------
`define WDC_SEL_RESET     2'h0
`define WDC_MASK_RESET    2'h0
`define WDC_KEY_FIRST     8'haa
`define WDC_KEY_SECOND    8'h55

// --------------------------------------------------------------
// timing counts
// --------------------------------------------------------------
`define WDC_TO_SEL0       131072
`define WDC_TO_SEL1       1048576
`define WDC_TO_SEL2       8388608
`define WDC_TO_SEL3       67108864
`define WDC_CNT_W         26
`define WDC_RST_DELAY     10'd512
`define WDC_MC_CLKS       4'd4
`define WDC_RST_MC        4'd2
`define WDC_RST_LEN       (`WDC_MC_CLKS * `WDC_RST_MC)
`define WDC_TA_WINDOW     4'd12

`endif

/* testbench/wdc_props.sv */
// Purpose: concurrent checks on the watchdog control block ports
// Assumes: RDATA is registered and reads zero outside its answer cycle
// Notes:   bound to every wdc_top instance
`timescale 1ns/1ps
`include "wdc_defines.vh"

module wdc_props (
  input wire                   CORE_CLK,
  input wire                   ARST_N,
  input wire [`WDC_ADDR_W-1:0] ADDR,
  input wire [7:0]             WDATA,
  input wire                   WR,
  input wire                   RD,
  input wire [7:0]             RDATA,
  input wire                   PWR_ON_RST,
  input wire                   PWR_FAIL_RST,
  input wire                   EXT_RST,
  input wire                   WD_IRQ_REQ,
  input wire                   WD_RST_OUT,
  input wire                   IRQ
);
  // --------------------------------------------------------------
  // properties, one clock domain
  // --------------------------------------------------------------
  default clocking dc @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data driven without a read");
  a_ctrl_reserved: assert property (
    $past(RD) && $past(ADDR) == `WDC_OFF_CONTROL |-> (RDATA & 8'hb1) == 8'h00)
    else $error("reserved or restart bit reads one");
  a_unmapped_zero: assert property (
    $past(RD) && $past(ADDR) > `WDC_OFF_MASK |-> RDATA == 8'h00)
    else $error("unmapped address returned data");
  a_rst_length: assert property (
    $rose(WD_RST_OUT) |-> WD_RST_OUT [*8] ##1 !WD_RST_OUT)
    else $error("watchdog reset pulse not eight cycles");
  a_rst_gap: assert property (
    $fell(WD_RST_OUT) |-> !WD_RST_OUT [*8])
    else $error("watchdog reset repeated too soon");
  a_rst_after_power: assert property (
    $rose(WD_RST_OUT) |-> !$past(PWR_ON_RST) && !$past(PWR_FAIL_RST))
    else $error("watchdog reset right after a power reset");
  a_power_irq_off: assert property (
    PWR_ON_RST || PWR_FAIL_RST |-> ##2 !WD_IRQ_REQ)
    else $error("watchdog request survives a power reset");
  a_irq_clear_cause: assert property (
    $fell(IRQ) |-> $past(RD, 2) || $past(WR, 2) || $past(PWR_FAIL_RST, 2)
      || $past(RD) || $past(WR) || $past(PWR_FAIL_RST))
    else $error("interrupt dropped without software action");
endmodule

bind wdc_top wdc_props u_props (
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .PWR_ON_RST(PWR_ON_RST), .PWR_FAIL_RST(PWR_FAIL_RST),
  .EXT_RST(EXT_RST), .WD_IRQ_REQ(WD_IRQ_REQ), .WD_RST_OUT(WD_RST_OUT), .IRQ(IRQ));

/* testbench/testbench.sv */
// Purpose: self-checking bench for the watchdog control block
// Assumes: timeout counts shortened to 16, 32, 64 and 128 clocks
// Notes:   read results are queued by the driver and compared by a monitor
`timescale 1ns/1ps
`include "wdc_defines.vh"

module testbench;
  localparam int IV0 = 16; // shortest bench interval, doubling per select step
  logic                   core_clk;
  logic                   arst_n = 1'b0;
  logic [`WDC_ADDR_W-1:0] addr = '0;
  logic [7:0]             wdata = 8'h00;
  logic                   wr = 1'b0;
  logic                   rd = 1'b0;
  logic                   rd_d = 1'b0;
  logic                   pwr_on = 1'b0;
  logic                   pwr_fail = 1'b0;
  logic                   ext_rst = 1'b0;
  logic [7:0]             rdata;
  logic                   wd_irq_req;
  logic                   wd_rst_out;
  logic                   irq;
  logic [7:0]             exp_q[$];
  logic [7:0]             d;
  int                     errors = 0;
  int                     comparisons = 0;
  int                     cycles = 0;
  int                     rst_hits = 0;
  int                     n;

  wdc_top #(.TO_SEL0(16), .TO_SEL1(32), .TO_SEL2(64), .TO_SEL3(128)) DUT (
    .CORE_CLK(core_clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .PWR_ON_RST(pwr_on), .PWR_FAIL_RST(pwr_fail),
    .EXT_RST(ext_rst), .WD_IRQ_REQ(wd_irq_req), .WD_RST_OUT(wd_rst_out), .IRQ(irq));

  // --------------------------------------------------------------
  // clock, checking and bus tasks
  // --------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  // the expectation is queued before the answer cycle starts
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    rd <= 1'b0;
  endtask

  task automatic unlocked(input logic [7:0] v);
    wr_reg(`WDC_OFF_TA_KEY, `WDC_KEY_FIRST);
    wr_reg(`WDC_OFF_TA_KEY, `WDC_KEY_SECOND);
    wr_reg(`WDC_OFF_CONTROL, v);
  endtask

  task automatic power_fail();
    @(posedge core_clk);
    pwr_fail <= 1'b1;
    @(posedge core_clk);
    pwr_fail <= 1'b0;
  endtask

  // monitor samples read data mid-cycle, away from the launching edge
  always @(posedge core_clk) begin
    rd_d <= rd;
    cycles <= cycles + 1;
    if (wd_rst_out) rst_hits <= rst_hits + 1;
  end

  always @(negedge core_clk) begin
    if (rd_d) check(rdata, exp_q.pop_front());
    if (cycles >= 20000) begin
      errors++;
      report_and_stop();
    end
  end

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    void'($urandom(32'h9c26));
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int a = 0; a < 6; a++) rd_reg(a[3:0], 8'h00);
    @(posedge core_clk);
    pwr_on <= 1'b1;
    @(posedge core_clk);
    pwr_on <= 1'b0;
    rd_reg(`WDC_OFF_CONTROL, 8'h40);
    d = 8'($urandom);
    wr_reg(`WDC_OFF_CONTROL, d);
    rd_reg(`WDC_OFF_CONTROL, d & 8'h40);
    // a stray key byte must drop the half-finished unlock
    wr_reg(`WDC_OFF_TA_KEY, `WDC_KEY_FIRST);
    wr_reg(`WDC_OFF_TA_KEY, 8'h33);
    wr_reg(`WDC_OFF_TA_KEY, `WDC_KEY_SECOND);
    wr_reg(`WDC_OFF_CONTROL, 8'h02);
    rd_reg(`WDC_OFF_CONTROL, 8'h00);
    wr_reg(4'hf, d);
    rd_reg(4'hf, 8'h00);
    rd_reg(4'h6, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr_reg(`WDC_OFF_IRQ_EN, (s % 2 == 0) ? 8'h10 : 8'h00);
      wr_reg(`WDC_OFF_MASK, (s < 2) ? 8'h01 : 8'h00);
      wr_reg(`WDC_OFF_CLK_CTRL, 8'(s << 6));
      rd_reg(`WDC_OFF_CLK_CTRL, 8'(s << 6));
      @(posedge core_clk);
      ext_rst <= 1'b1;
      @(posedge core_clk);
      ext_rst <= 1'b0;
      unlocked(8'h01);
      repeat ((IV0 << s) - 4) @(posedge core_clk);
      rd_reg(`WDC_OFF_CONTROL, 8'h00);
      repeat (6) @(posedge core_clk);
      rd_reg(`WDC_OFF_CONTROL, 8'h08);
      #1;
      check(wd_irq_req, s % 2 == 0);
      check(irq, s < 2);
      rd_reg(`WDC_OFF_STATUS, 8'h01);
      rd_reg(`WDC_OFF_STATUS, 8'h00);
      power_fail();
      #1;
      check(irq, 1'b0);
      rd_reg(`WDC_OFF_CONTROL, 8'h08);
      unlocked(8'h00);
      rd_reg(`WDC_OFF_CONTROL, 8'h00);
    end
    // reset path: shortest interval, wait out the delay
    wr_reg(`WDC_OFF_CLK_CTRL, 8'h00);
    wr_reg(`WDC_OFF_MASK, 8'h02);
    unlocked(8'h03);
    n = 0;
    while (!wd_rst_out && n < 800) begin
      @(negedge core_clk);
      n++;
    end
    check(n >= IV0 + 512 && n <= IV0 + 516, 1'b1);
    n = 0;
    while (wd_rst_out && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    check(8'(n), 8'd8);
    rd_reg(`WDC_OFF_CONTROL, 8'h0e);
    #1;
    check(irq, 1'b1);
    rd_reg(`WDC_OFF_STATUS, 8'h03);
    n = rst_hits;
    repeat (4) begin
      unlocked(8'h03);
      repeat (200) @(posedge core_clk);
    end
    power_fail();
    check(8'(rst_hits - n), 8'h00);
    rd_reg(`WDC_OFF_CONTROL, 8'h08);
    unlocked(8'h01);
    repeat (600) @(posedge core_clk);
    check(8'(rst_hits - n), 8'h00);
    rd_reg(`WDC_OFF_CONTROL, 8'h08);
    repeat (2) @(posedge core_clk);
    report_and_stop();
  end
endmodule
